// file: verilog/ddpi_map.svh
// offsets, field positions, reset values and counts of the drive process image
// Summary of operation
// R1: the module exchanges exactly six bytes of input image and six bytes of output image with the controller.
// R2: position data takes at most four bytes per direction, numbered zero to three.
// R3: two control bytes from the controller and two status bytes from the module govern module and drive.
// R4: in normal view the input data bytes carry actual position and the output data bytes the setpoint.
// R5: in extended view the input data bytes carry extended status bytes two to five instead of position.
// R6: in extended view the data flow is steered by control bytes one to three and status bytes one to three.
// R7: the controller asks for extended view by setting bit 3 of control byte one and leaves it by clearing it.
// R8: the module acknowledges a finished view switch by letting bit 3 of status byte one follow the request.
// R9: word zero holds status or control bytes zero and one, words one and two hold position, low byte first.
`ifndef DDPI_MAP_SVH
`define DDPI_MAP_SVH
`define DDPI_IMAGE_BYTES 3'h6
`define DDPI_WORDS 2'h3
`define DDPI_ADDR_W 2
`define DDPI_WORD_CTRL 2'h0
`define DDPI_WORD_POS_LO 2'h1
`define DDPI_WORD_POS_HI 2'h2
`define DDPI_VIEW_BIT 3
`define DDPI_RST_BYTE 8'h00
`define DDPI_RST_WORD 16'h0000
`define DDPI_SWITCH_CYCLES 4'h2
`endif

// file: verilog/ddpi_pkg.sv
// types of the drive process image
package ddpi_pkg;
  typedef enum logic [1:0] {
    DDPI_VIEW_POS = 2'b00,
    DDPI_VIEW_SWITCH = 2'b01,
    DDPI_VIEW_EXT = 2'b10
  } ddpi_view_e;

  // drive side status and position as seen by the module
  typedef struct packed {
    logic [7:0] stat_byte_zero;
    logic [7:0] stat_byte_one;
    logic [31:0] act_pos;
    logic [7:0] ext_stat_byte_two;
    logic [7:0] ext_stat_byte_three;
    logic [7:0] ext_stat_byte_four;
    logic [7:0] ext_stat_byte_five;
  } ddpi_drive_in_s;

  // commands towards the drive
  typedef struct packed {
    logic [7:0] ctrl_byte_zero;
    logic [7:0] ctrl_byte_one;
    logic [7:0] ctrl_byte_two;
    logic [7:0] ctrl_byte_three;
    logic [31:0] setpoint_pos;
    logic ext_view;
  } ddpi_drive_out_s;
endpackage

// file: verilog/ddpi_view_switch.sv
// view switch sequencer with acknowledge
module ddpi_view_switch (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // request and acknowledge
  input wire logic view_req,
  output logic view_ack,
  output logic ext_active
);
  import ddpi_pkg::*;
  `include "ddpi_map.svh"

  typedef struct packed {
    ddpi_view_e state;
    logic [3:0] cnt;
    logic ack;
  } ddpi_vs_s;

  ddpi_vs_s st_r;
  ddpi_vs_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    case (st_r.state)
      DDPI_VIEW_POS: begin
        if (view_req) begin
          st_nxt.state = DDPI_VIEW_SWITCH;
          st_nxt.cnt = `DDPI_SWITCH_CYCLES;
        end
      end
      DDPI_VIEW_EXT: begin
        if (!view_req) begin
          st_nxt.state = DDPI_VIEW_SWITCH;
          st_nxt.cnt = `DDPI_SWITCH_CYCLES;
        end
      end
      DDPI_VIEW_SWITCH: begin
        // the data mux and the ack both follow st_r.ack and switch on the same edge, so the host never sees a mixed image
        if (st_r.cnt > 4'h1) begin
          st_nxt.cnt = st_r.cnt - 4'h1;
        end else begin
          st_nxt.cnt = 4'h0;
          st_nxt.ack = view_req; // R8
          st_nxt.state = view_req ? DDPI_VIEW_EXT : DDPI_VIEW_POS;
        end
      end
      default: begin
        st_nxt.state = DDPI_VIEW_POS;
        st_nxt.cnt = 4'h0;
        st_nxt.ack = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '{state: DDPI_VIEW_POS, cnt: 4'h0, ack: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign view_ack = st_r.ack;
  assign ext_active = st_r.ack;
endmodule

// file: verilog/ddpi_image.sv
// process image exchange for a dc drive module
module ddpi_image (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // controller side process image port
  input wire logic [1:0] pi_addr,
  input wire logic [15:0] pi_wdata,
  input wire logic pi_wr,
  input wire logic pi_rd,
  output logic [15:0] pi_rdata,
  // drive side
  input wire ddpi_pkg::ddpi_drive_in_s drive_in,
  output ddpi_pkg::ddpi_drive_out_s drive_out
);
  import ddpi_pkg::*;
  `include "ddpi_map.svh"

  typedef struct packed {
    logic [7:0] ctrl_byte_zero;
    logic [7:0] ctrl_byte_one;
    logic [7:0] ctrl_byte_two;
    logic [7:0] ctrl_byte_three;
    logic [31:0] setpoint_pos;
    logic [15:0] rdata;
  } ddpi_img_s;

  ddpi_img_s st_r;
  ddpi_img_s st_nxt;
  logic view_ack;
  logic ext_active;
  logic [7:0] stat_one_view;
  logic [31:0] in_data;

  ddpi_view_switch u_switch (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .view_req(st_r.ctrl_byte_one[`DDPI_VIEW_BIT]), // R7
    .view_ack(view_ack),
    .ext_active(ext_active)
  );

  always_comb begin
    stat_one_view = drive_in.stat_byte_one;
    stat_one_view[`DDPI_VIEW_BIT] = view_ack; // R8
    // R4 R5
    if (ext_active) begin
      in_data = {drive_in.ext_stat_byte_five, drive_in.ext_stat_byte_four,
                 drive_in.ext_stat_byte_three, drive_in.ext_stat_byte_two};
    end else begin
      in_data = drive_in.act_pos;
    end
  end

  always_comb begin
    st_nxt = st_r;
    // only three words decode; word three writes are dropped and reads return zero, keeping six bytes
    if (pi_wr) begin // R1
      case (pi_addr)
        `DDPI_WORD_CTRL: begin
          st_nxt.ctrl_byte_zero = pi_wdata[7:0]; // R3 R9
          st_nxt.ctrl_byte_one = pi_wdata[15:8];
        end
        `DDPI_WORD_POS_LO: st_nxt.setpoint_pos[15:0] = pi_wdata; // R2 R9
        `DDPI_WORD_POS_HI: begin
          // extended view: word two carries the auxiliary control bytes two and three
          if (ext_active) begin // R6
            st_nxt.ctrl_byte_two = pi_wdata[7:0];
            st_nxt.ctrl_byte_three = pi_wdata[15:8];
          end else begin
            st_nxt.setpoint_pos[31:16] = pi_wdata;
          end
        end
        default: st_nxt.setpoint_pos = st_r.setpoint_pos;
      endcase
    end
    st_nxt.rdata = `DDPI_RST_WORD;
    if (pi_rd) begin
      case (pi_addr)
        `DDPI_WORD_CTRL: st_nxt.rdata = {stat_one_view, drive_in.stat_byte_zero}; // R3 R9
        `DDPI_WORD_POS_LO: st_nxt.rdata = in_data[15:0];
        `DDPI_WORD_POS_HI: st_nxt.rdata = in_data[31:16];
        default: st_nxt.rdata = `DDPI_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '{ctrl_byte_zero: `DDPI_RST_BYTE, ctrl_byte_one: `DDPI_RST_BYTE,
                ctrl_byte_two: `DDPI_RST_BYTE, ctrl_byte_three: `DDPI_RST_BYTE,
                setpoint_pos: 32'h0000_0000, rdata: `DDPI_RST_WORD};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pi_rdata = st_r.rdata;
  assign drive_out = '{ctrl_byte_zero: st_r.ctrl_byte_zero, ctrl_byte_one: st_r.ctrl_byte_one,
                       ctrl_byte_two: st_r.ctrl_byte_two, ctrl_byte_three: st_r.ctrl_byte_three,
                       setpoint_pos: st_r.setpoint_pos, ext_view: ext_active};
endmodule

// file: verif/ddpi_image_sva.sv
// port assertions for the drive process image
module ddpi_image_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // image port
  input wire logic [1:0] pi_addr,
  input wire logic [15:0] pi_wdata,
  input wire logic pi_wr,
  input wire logic pi_rd,
  input wire logic [15:0] pi_rdata,
  // drive side
  input wire ddpi_pkg::ddpi_drive_in_s drive_in,
  input wire ddpi_pkg::ddpi_drive_out_s drive_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import ddpi_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_c0; pi_wr && pi_addr == 2'h0 |=> drive_out.ctrl_byte_zero == $past(pi_wdata[7:0]); endproperty
  a_c0: assert property (p_c0) else $error("ctrl zero");
  property p_c1; pi_wr && pi_addr == 2'h0 |=> drive_out.ctrl_byte_one == $past(pi_wdata[15:8]); endproperty
  a_c1: assert property (p_c1) else $error("ctrl one");
  property p_sp; pi_wr && pi_addr == 2'h1 |=> drive_out.setpoint_pos[15:0] == $past(pi_wdata); endproperty
  a_sp: assert property (p_sp) else $error("setpoint");
  property p_pos; pi_rd && pi_addr == 2'h1 && !drive_out.ext_view |=> pi_rdata == $past(drive_in.act_pos[15:0]);
  endproperty
  a_pos: assert property (p_pos) else $error("position");
  property p_ext; pi_rd && pi_addr == 2'h2 && drive_out.ext_view |=>
    pi_rdata[7:0] == $past(drive_in.ext_stat_byte_four);
  endproperty
  a_ext: assert property (p_ext) else $error("ext status");
  property p_ack; pi_rd && pi_addr == 2'h0 |=> pi_rdata[11] == $past(drive_out.ext_view); endproperty
  a_ack: assert property (p_ack) else $error("ack bit");
  property p_sw; $rose(drive_out.ctrl_byte_one[3]) |-> ##3 drive_out.ext_view; endproperty
  a_sw: assert property (p_sw) else $error("view switch");
  property p_swoff; $fell(drive_out.ctrl_byte_one[3]) |-> ##3 !drive_out.ext_view; endproperty
  a_swoff: assert property (p_swoff) else $error("view switch back");
  property p_unm; pi_rd && pi_addr == 2'h3 |=> pi_rdata == 16'h0000; endproperty
  a_unm: assert property (p_unm) else $error("unmapped");
endmodule
bind ddpi_image ddpi_image_sva u_sva (.core_clk(core_clk), .rst_b(rst_b), .pi_addr(pi_addr), .pi_wdata(pi_wdata),
  .pi_wr(pi_wr), .pi_rd(pi_rd), .pi_rdata(pi_rdata), .drive_in(drive_in), .drive_out(drive_out));

// file: verif/ddpi_ctl_model.sv
// controller model issuing image reads and writes
module ddpi_ctl_model (
  // clock
  input wire logic core_clk,
  // image port
  output logic [1:0] pi_addr,
  output logic [15:0] pi_wdata,
  output logic pi_wr,
  output logic pi_rd,
  input wire logic [15:0] pi_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pi_addr = 2'h0;
    pi_wdata = 16'h0000;
    pi_wr = 1'b0;
    pi_rd = 1'b0;
  end
  task wr(input logic [1:0] a, input logic [15:0] v);
    @(posedge core_clk);
    pi_addr <= a;
    pi_wdata <= v;
    pi_wr <= 1'b1;
    @(posedge core_clk);
    pi_wr <= 1'b0;
    #1;
  endtask
  // read data only stands one cycle, so it is taken just after the release edge
  task rd(input logic [1:0] a, output logic [15:0] v);
    @(posedge core_clk);
    pi_addr <= a;
    pi_rd <= 1'b1;
    @(posedge core_clk);
    pi_rd <= 1'b0;
    #1 v = pi_rdata;
  endtask
endmodule

// file: verif/tb.sv
// self-checking bench for the drive process image
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ddpi_pkg::*;
  logic core_clk, rst_b, pi_wr, pi_rd;
  logic [1:0] pi_addr;
  logic [15:0] pi_wdata, pi_rdata, d;
  ddpi_drive_in_s drive_in;
  ddpi_drive_out_s drive_out;
  int err_total, cmp_count;
  ddpi_image u_ddpi_image (.core_clk(core_clk), .rst_b(rst_b), .pi_addr(pi_addr), .pi_wdata(pi_wdata),
    .pi_wr(pi_wr), .pi_rd(pi_rd), .pi_rdata(pi_rdata), .drive_in(drive_in), .drive_out(drive_out));
  ddpi_ctl_model u_ctl (.core_clk(core_clk), .pi_addr(pi_addr), .pi_wdata(pi_wdata), .pi_wr(pi_wr),
    .pi_rd(pi_rd), .pi_rdata(pi_rdata));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task results;
    $display("mismatches %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task t_pos;
    u_ctl.wr(2'h1, 16'h1234);
    u_ctl.wr(2'h2, 16'h5678);
    chk(drive_out.setpoint_pos, 32'h56781234);
    u_ctl.rd(2'h1, d);
    chk(d, 16'hCDEF);
    u_ctl.rd(2'h2, d);
    chk(d, 16'h89AB);
    u_ctl.rd(2'h0, d);
    chk(d, 16'h215A);
    u_ctl.rd(2'h3, d);
    chk(d, 16'h0000);
    u_ctl.wr(2'h3, 16'hFFFF);
    chk(drive_out.setpoint_pos, 32'h56781234);
    chk({drive_out.ctrl_byte_one, drive_out.ctrl_byte_zero}, 16'h0000);
  endtask
  task t_ext;
    u_ctl.wr(2'h0, 16'h0811);
    chk(drive_out.ctrl_byte_one, 8'h08);
    repeat (4) @(posedge core_clk);
    #1 chk(drive_out.ext_view, 1'b1);
    u_ctl.rd(2'h0, d);
    chk(d, 16'h295A);
    u_ctl.rd(2'h1, d);
    chk(d, 16'h3322);
    u_ctl.rd(2'h2, d);
    chk(d, 16'h5544);
    u_ctl.wr(2'h2, 16'hBEEF);
    chk({drive_out.ctrl_byte_three, drive_out.ctrl_byte_two, drive_out.setpoint_pos[31:16]}, 32'hBEEF5678);
    u_ctl.wr(2'h0, 16'h0000);
    repeat (4) @(posedge core_clk);
    #1 chk(drive_out.ext_view, 1'b0);
    u_ctl.rd(2'h1, d);
    chk(d, 16'hCDEF);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    repeat (400) @(posedge core_clk);
    err_total++;
    results;
  end
  initial begin
    rst_b = 1'b0;
    err_total = 0;
    cmp_count = 0;
    drive_in = {8'h5A, 8'h29, 32'h89ABCDEF, 8'h22, 8'h33, 8'h44, 8'h55};
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    t_pos;
    t_ext;
    results;
  end
endmodule
